// ==== jlp_regs.sv ====
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module jlp_regs (
	input  wire logic                          clock,         // 200 MHz
	input  wire logic                          resetn,        // Sync reset, low
	input  wire logic [13:0]                   s_axi_awaddr,  // Write address
	input  wire logic                          s_axi_awvalid, // Write addr valid
	output logic                               s_axi_awready, // Write addr ready
	input  wire logic [31:0]                   s_axi_wdata,   // Write data
	input  wire logic [3:0]                    s_axi_wstrb,   // Byte strobes
	input  wire logic                          s_axi_wvalid,  // Write data valid
	output logic                               s_axi_wready,  // Write data ready
	output logic [1:0]                         s_axi_bresp,   // Write response
	output logic                               s_axi_bvalid,  // Response valid
	input  wire logic                          s_axi_bready,  // Response ready
	input  wire logic [13:0]                   s_axi_araddr,  // Read address
	input  wire logic                          s_axi_arvalid, // Read addr valid
	output logic                               s_axi_arready, // Read addr ready
	output logic [31:0]                        s_axi_rdata,   // Read data
	output logic [1:0]                         s_axi_rresp,   // Read response
	output logic                               s_axi_rvalid,  // Read data valid
	input  wire logic                          s_axi_rready,  // Read ready
	input  wire jlp_pkg::jlp_lane_s [2:0]      lane_in,       // Lanes 5..7 capture
	output jlp_pkg::jlp_cfg_s                  cfg_out        // Link parameters
);
	// Lane status storage, one entry per lane
	logic [7:0] chk [3];
	logic [7:0] cmp [3];
	logic [4:0] lid [3];
	logic [7:0] next_chk [3];
	logic [7:0] next_cmp [3];
	logic [4:0] next_lid [3];
	logic       mode;
	jlp_pkg::jlp_cfg_s cfg;
	jlp_pkg::jlp_cfg_s next_cfg;
	logic       aw_held, w_held, next_aw_held, next_w_held;
	logic [11:0] aw_idx, next_aw_idx;
	logic [31:0] wd, next_wd;
	logic [3:0]  ws, next_ws;
	logic        bv, next_bv, rv, next_rv;
	logic [1:0]  br, next_br, rr, next_rr;
	logic [31:0] rd, next_rd;
	logic        hit_w, hit_r;
	logic [7:0]  rbyte;

	// Capture each lane when its link configuration is complete
	genvar g;
	generate
		for (g = 0; g < jlp_pkg::NLANE; g++) begin : g_lane
			always_comb begin
				next_chk[g] = chk[g];
				next_cmp[g] = cmp[g];
				next_lid[g] = lid[g];
				if (lane_in[g].valid) begin
					next_chk[g] = lane_in[g].cfg_checksum;
					// Method picked by the mode bit
					next_cmp[g] = mode ? lane_in[g].sum_fields
						: lane_in[g].sum_octets;
					next_lid[g] = lane_in[g].lane_ident;
				end
			end
			always_ff @(posedge clock) begin
				if (!resetn) begin
					chk[g] <= jlp_pkg::RST_ZERO;
					cmp[g] <= jlp_pkg::RST_ZERO;
					lid[g] <= 5'h00;
				end else begin
					chk[g] <= next_chk[g];
					cmp[g] <= next_cmp[g];
					lid[g] <= next_lid[g];
				end
			end
		end
	endgenerate

	// Byte merge under write strobe lane 0; upper lanes land in zero bits
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_idx  = aw_idx;
		next_wd      = wd;
		next_ws      = ws;
		next_cfg     = cfg;
		next_bv      = bv;
		next_br      = br;
		hit_w        = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_idx  = s_axi_awaddr[13:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_wd     = s_axi_wdata;
			next_ws     = s_axi_wstrb;
		end
		if (bv && s_axi_bready) begin
			next_bv = 1'b0;
		end
		if (next_aw_held && next_w_held && !bv) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bv      = 1'b1;
			hit_w        = 1'b1;
			// Read-only and reserved bits are never stored
			if (next_aw_idx == jlp_pkg::IDX_DEV_IDENT) begin
				if (next_ws[0]) next_cfg.expected_device_ident = next_wd[7:0];
			end else if (next_aw_idx == jlp_pkg::IDX_BANK_IDENT) begin
				if (next_ws[0]) begin
					next_cfg.lmfc_adjust_resolution = next_wd[7:4];
					next_cfg.expected_bank_ident    = next_wd[3:0];
				end
			end else if (next_aw_idx == jlp_pkg::IDX_LANE0_IDENT) begin
				if (next_ws[0]) begin
					next_cfg.lmfc_adjust_direction = next_wd[6];
					next_cfg.phase_adjust_request  = next_wd[5];
					next_cfg.expected_lane0_ident  = next_wd[4:0];
				end
			end else if (next_aw_idx == jlp_pkg::IDX_SCRL) begin
				if (next_ws[0]) begin
					next_cfg.payload_whitening_removal_enable =
						next_wd[jlp_pkg::WHITEN_BIT];
					next_cfg.lane_count_m1 = next_wd[4:0];
				end
			end else if (next_aw_idx == jlp_pkg::IDX_MODE) begin
				if (next_ws[0]) next_cfg.checksum_mode = next_wd[jlp_pkg::MODE_BIT];
			end else if (next_aw_idx == jlp_pkg::IDX_CHK5 || next_aw_idx == jlp_pkg::IDX_CMP5
				|| next_aw_idx == jlp_pkg::IDX_LID6 || next_aw_idx == jlp_pkg::IDX_CHK6
				|| next_aw_idx == jlp_pkg::IDX_CMP6 || next_aw_idx == jlp_pkg::IDX_LID7
				|| next_aw_idx == jlp_pkg::IDX_CHK7 || next_aw_idx == jlp_pkg::IDX_CMP7) begin
				hit_w = 1'b1;
			end else begin
				hit_w = 1'b0;
			end
			next_br = hit_w ? jlp_pkg::RESP_OKAY : jlp_pkg::RESP_SLVERR;
		end
	end

	// Write channel registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_idx  <= 12'h000;
			wd      <= 32'h0000_0000;
			ws      <= 4'h0;
			bv      <= 1'b0;
			br      <= 2'h0;
			cfg     <= '0;
			cfg.payload_whitening_removal_enable <= jlp_pkg::RST_SCRL[7];
			cfg.lane_count_m1 <= jlp_pkg::RST_SCRL[4:0];
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			aw_idx  <= next_aw_idx;
			wd      <= next_wd;
			ws      <= next_ws;
			bv      <= next_bv;
			br      <= next_br;
			cfg     <= next_cfg;
		end
	end
	assign mode = cfg.checksum_mode;

	// Read decode; reserved bits return zero
	always_comb begin
		rbyte = 8'h00;
		hit_r = 1'b1;
		if (s_axi_araddr[13:2] == jlp_pkg::IDX_CHK5) begin
			rbyte = chk[0];
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_CMP5) begin
			rbyte = cmp[0];
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_LID6) begin
			rbyte = {3'h0, lid[1]};
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_CHK6) begin
			rbyte = chk[1];
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_CMP6) begin
			rbyte = cmp[1];
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_LID7) begin
			rbyte = {3'h0, lid[2]};
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_CHK7) begin
			rbyte = chk[2];
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_CMP7) begin
			rbyte = cmp[2];
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_DEV_IDENT) begin
			rbyte = cfg.expected_device_ident;
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_BANK_IDENT) begin
			rbyte = {cfg.lmfc_adjust_resolution, cfg.expected_bank_ident};
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_LANE0_IDENT) begin
			rbyte = {1'b0, cfg.lmfc_adjust_direction, cfg.phase_adjust_request,
				cfg.expected_lane0_ident};
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_SCRL) begin
			rbyte = {cfg.payload_whitening_removal_enable, 2'h0, cfg.lane_count_m1};
		end else if (s_axi_araddr[13:2] == jlp_pkg::IDX_MODE) begin
			rbyte = {1'b0, cfg.checksum_mode, 6'h00};
		end else begin
			hit_r = 1'b0;
		end
	end

	// Read channel: one read in flight
	always_comb begin
		next_rv = rv;
		next_rd = rd;
		next_rr = rr;
		if (rv && s_axi_rready) begin
			next_rv = 1'b0;
		end
		// Only a real address handshake may start an answer
		if (s_axi_arvalid && s_axi_arready && !rv) begin
			next_rv = 1'b1;
			next_rd = {24'h000000, rbyte};
			next_rr = hit_r ? jlp_pkg::RESP_OKAY : jlp_pkg::RESP_SLVERR;
		end
	end

	// Read registers and registered ready outputs
	always_ff @(posedge clock) begin
		if (!resetn) begin
			rv            <= 1'b0;
			rd            <= 32'h0000_0000;
			rr            <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			rv            <= next_rv;
			rd            <= next_rd;
			rr            <= next_rr;
			// Ready only while idle so a held beat is taken exactly once
			s_axi_arready <= ~next_rv & ~(s_axi_arvalid & s_axi_arready);
			s_axi_awready <= ~next_aw_held & ~next_bv & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~next_w_held & ~next_bv & ~(s_axi_wvalid & s_axi_wready);
		end
	end

	// Registered outputs
	always_ff @(posedge clock) begin
		if (!resetn) begin
			cfg_out <= '0;
			// Receiver sees the documented defaults even while held in reset
			cfg_out.payload_whitening_removal_enable <= jlp_pkg::RST_SCRL[7];
			cfg_out.lane_count_m1 <= jlp_pkg::RST_SCRL[4:0];
		end else begin
			cfg_out <= next_cfg;
		end
	end
	assign s_axi_bvalid = bv;
	assign s_axi_bresp  = br;
	assign s_axi_rvalid = rv;
	assign s_axi_rdata  = rd;
	assign s_axi_rresp  = rr;

	// Lane 7 ident upper bits always zero
	lid_rsvd_a: assert property (@(posedge clock) disable iff (!resetn)
		s_axi_rvalid && $past(s_axi_araddr[13:2]) == jlp_pkg::IDX_LID7
		&& $past(s_axi_arvalid && s_axi_arready) |-> s_axi_rdata[31:5] == 27'h0)
		else $error("lane ident reserved bits nonzero");
	// Capture lands next cycle
	chk_cap_a: assert property (@(posedge clock) disable iff (!resetn)
		lane_in[0].valid |=> chk[0] == $past(lane_in[0].cfg_checksum))
		else $error("received checksum not captured");
	cmp_sel_a: assert property (@(posedge clock) disable iff (!resetn)
		lane_in[1].valid && mode |=> cmp[1] == $past(lane_in[1].sum_fields))
		else $error("computed checksum method wrong");
	cmp_oct_a: assert property (@(posedge clock) disable iff (!resetn)
		lane_in[2].valid && !mode |=> cmp[2] == $past(lane_in[2].sum_octets))
		else $error("computed checksum not captured");
	rst_scr_a: assert property (@(posedge clock)
		$rose(resetn) |-> cfg.payload_whitening_removal_enable)
		else $error("whitening enable reset wrong");
	rst_cnt_a: assert property (@(posedge clock)
		$rose(resetn) |-> cfg.lane_count_m1 == 5'h03)
		else $error("lane count reset wrong");
	ro_hold_a: assert property (@(posedge clock) disable iff (!resetn)
		!lane_in[0].valid |=> $stable(chk[0]))
		else $error("read-only register changed");
	bresp_slot_a: assert property (@(posedge clock) disable iff (!resetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	cfg_out_a: assert property (@(posedge clock) disable iff (!resetn)
		##1 cfg_out == cfg)
		else $error("config output lags");

	// Bus answers one edge after acceptance, readys drop meanwhile
	sequence ar_taken_s;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence r_answer_s;
		s_axi_rvalid && !s_axi_arready;
	endsequence
	rd_answer_a: assert property (@(posedge clock) disable iff (!resetn)
		ar_taken_s |=> r_answer_s)
		else $error("read answer missing");
	sequence aw_w_taken_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	wr_answer_a: assert property (@(posedge clock) disable iff (!resetn)
		aw_w_taken_s |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("write answer missing");
	// Reserved bits of the lane count register read back as zero
	sequence scrl_read_s;
		ar_taken_s ##0 s_axi_araddr[13:2] == jlp_pkg::IDX_SCRL;
	endsequence
	scrl_rsvd_a: assert property (@(posedge clock) disable iff (!resetn)
		scrl_read_s |=> s_axi_rvalid && s_axi_rdata[6:5] == 2'h0)
		else $error("lane count reserved bits nonzero");
	// A completed write of the enable reaches the receiver next edge
	sequence scrl_write_s;
		hit_w && next_aw_idx == jlp_pkg::IDX_SCRL && next_ws[0];
	endsequence
	scr_wr_a: assert property (@(posedge clock) disable iff (!resetn)
		scrl_write_s |=> cfg_out.payload_whitening_removal_enable
			== $past(next_wd[jlp_pkg::WHITEN_BIT]))
		else $error("whitening enable write lost");
endmodule

// ==== jlp_pkg.sv ====
// Operation
// - Lanes 5-7: read-only received link checksum, 8 bits, resets to zero.
// - Lanes 5-7: read-only computed checksum over received link data, resets zero.
// - Lanes 6-7: read-only 5-bit received lane ident, bits 7:5 read zero.
// - Whitening removal bit 7 enables descrambling when set; resets to one.
// - Lane count field is lanes minus one; resets to three.
// - Checksum mode bit selects computation method; computed should match received.
package jlp_pkg;
	localparam int AW = 12;
	// Printed offsets are not all word multiples, so they are indices
	localparam logic [AW-1:0] IDX_CHK5  = 12'h435;
	localparam logic [AW-1:0] IDX_CMP5  = 12'h436;
	localparam logic [AW-1:0] IDX_LID6  = 12'h43a;
	localparam logic [AW-1:0] IDX_CHK6  = 12'h43d;
	localparam logic [AW-1:0] IDX_CMP6  = 12'h43e;
	localparam logic [AW-1:0] IDX_LID7  = 12'h442;
	localparam logic [AW-1:0] IDX_CHK7  = 12'h445;
	localparam logic [AW-1:0] IDX_CMP7  = 12'h446;
	localparam logic [AW-1:0] IDX_DEV_IDENT   = 12'h450;
	localparam logic [AW-1:0] IDX_BANK_IDENT  = 12'h451;
	localparam logic [AW-1:0] IDX_LANE0_IDENT = 12'h452;
	localparam logic [AW-1:0] IDX_SCRL  = 12'h453;
	localparam logic [AW-1:0] IDX_MODE  = 12'h300;
	localparam int MODE_BIT = 6;
	localparam int WHITEN_BIT = 7;
	localparam logic [7:0] RST_SCRL = 8'h83;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] MASK_LANE0 = 8'h7f;
	localparam logic [7:0] MASK_SCRL = 8'h9f;
	localparam logic [7:0] MASK_LID  = 8'h1f;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int NLANE = 3;
	localparam int FIRST_LANE = 5;

	// One lane's captured link configuration octets
	typedef struct packed {
		logic       valid;
		logic [4:0] lane_ident;
		logic [7:0] cfg_checksum;
		logic [7:0] sum_octets;
		logic [7:0] sum_fields;
	} jlp_lane_s;

	// Software link parameters toward the receiver
	typedef struct packed {
		logic [7:0] expected_device_ident;
		logic [3:0] lmfc_adjust_resolution;
		logic [3:0] expected_bank_ident;
		logic       lmfc_adjust_direction;
		logic       phase_adjust_request;
		logic [4:0] expected_lane0_ident;
		logic       payload_whitening_removal_enable;
		logic [4:0] lane_count_m1;
		logic       checksum_mode;
	} jlp_cfg_s;
endpackage

// ==== jlp_lane_tx.sv ====
`timescale 1ns/100ps
// Transmitter side of one lane: hands over its link configuration octets
module jlp_lane_tx (
	input  wire logic       clock, // Shared clock
	input  wire logic       send,  // One capture pulse
	input  wire logic [4:0] ident, // Lane ident sent
	input  wire logic [7:0] chk,   // Checksum octet sent
	input  wire logic [7:0] so,    // Octet sum
	input  wire logic [7:0] sf,    // Field sum
	output jlp_pkg::jlp_lane_s lane // Toward receiver
);
	initial lane = '0;
	// Off the pulse the fields turn to garbage so stale capture shows up
	always @(posedge clock) begin
		if (send) begin
			lane <= {1'b1, ident, chk, so, sf};
		end else begin
			lane <= {1'b0, ~lane[28:0]};
		end
	end
endmodule

// ==== jesd_rx_link_param_regs_tb_top.sv ====
`timescale 1ns/100ps
module jesd_rx_link_param_regs_tb_top;
	localparam logic [1:0] OK = 2'h0;
	localparam logic [1:0] ERR = 2'h2;
	localparam logic [11:0] RO [8] = '{12'h435, 12'h436, 12'h43a, 12'h43d,
		12'h43e, 12'h442, 12'h445, 12'h446};
	localparam logic [7:0] SCRL_SET [4] = '{8'h00, 8'h81, 8'h83, 8'h03};
	logic clock, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [13:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [2:0] send;
	logic [4:0] ident [3];
	logic [7:0] chk [3], so [3], sf [3];
	logic [7:0] v;
	logic [33:0] exp_q [$];
	int fail_count, tests_run, cyc, seed;
	wire jlp_pkg::jlp_lane_s [2:0] lane_in;
	jlp_pkg::jlp_cfg_s cfg_out;

	jlp_regs u_dut (.clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .lane_in(lane_in), .cfg_out(cfg_out));

	// One transmitter model per lane 5..7
	for (genvar k = 0; k < 3; k++) begin : g_tx
		jlp_lane_tx u_tx (.clock(clock), .send(send[k]), .ident(ident[k]),
			.chk(chk[k]), .so(so[k]), .sf(sf[k]), .lane(lane_in[k]));
	end

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Responses pair with the oldest note; one transfer in flight keeps order
	always @(posedge clock) begin
		if (bvalid && bready) check("bresp", exp_q.pop_front(), {32'h0, bresp});
		if (rvalid && rready) check("rdata", exp_q.pop_front(), {rresp, rdata});
	end

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			complete_run();
		end
	end

	// Handshakes sampled at the negedge before the edge that completes them
	task automatic axw(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] rs);
		logic a, w, b;
		exp_q.push_back({32'h0, rs});
		@(posedge clock);
		awaddr <= {idx, 2'b00};
		wdata <= {24'($random(seed)), d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clock);
			a = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			@(posedge clock);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] rs);
		logic a, r;
		exp_q.push_back({rs, 24'h0, d});
		@(posedge clock);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clock);
			a = arvalid && arready;
			r = rvalid;
			@(posedge clock);
			if (a) arvalid <= 1'b0;
		end while (!r);
		rready <= 1'b0;
	endtask

	initial begin
		seed = 56;
		fail_count = 0;
		tests_run = 0;
		cyc = 0;
		{resetn, awvalid, wvalid, bready, arvalid, rready, send} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		for (int k = 0; k < 3; k++) begin
			{ident[k], chk[k], so[k], sf[k]} = '0;
		end
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		repeat (2) @(posedge clock);
		// Reset values
		foreach (RO[i]) axr(RO[i], 8'h00, OK);
		axr(12'h450, 8'h00, OK);
		axr(12'h451, 8'h00, OK);
		axr(12'h452, 8'h00, OK);
		axr(12'h453, 8'h83, OK);
		axr(12'h300, 8'h00, OK);
		check("whiten", 34'h1, 34'(cfg_out.payload_whitening_removal_enable));
		check("lanes", 34'h3, 34'(cfg_out.lane_count_m1));
		$display("test reset done");
		// Read-only, reserved and unmapped places; adjust bits kept at zero
		foreach (RO[i]) axw(RO[i], 8'($random(seed)), OK);
		foreach (RO[i]) axr(RO[i], 8'h00, OK);
		axw(12'h437, 8'ha5, ERR);
		axr(12'h437, 8'h00, ERR);
		axw(12'h452, 8'h9f, OK);
		axr(12'h452, 8'h1f, OK);
		axw(12'h453, 8'hff, OK);
		axr(12'h453, 8'h9f, OK);
		$display("test protect done");
		// Software link parameters, kept to legal values
		v = 8'($random(seed));
		axw(12'h450, v, OK);
		axw(12'h451, {4'h0, v[3:0]}, OK);
		axw(12'h452, {3'h0, v[4:0]}, OK);
		axr(12'h450, v, OK);
		axr(12'h451, {4'h0, v[3:0]}, OK);
		axr(12'h452, {3'h0, v[4:0]}, OK);
		// Byte 0 strobe low leaves the register alone
		wstrb <= 4'he;
		axw(12'h450, ~v, OK);
		wstrb <= 4'hf;
		axr(12'h450, v, OK);
		check("did", 34'(v), 34'(cfg_out.expected_device_ident));
		check("bid", 34'(v[3:0]), 34'(cfg_out.expected_bank_ident));
		check("expected_lane0_ident", 34'(v[4:0]), 34'(cfg_out.expected_lane0_ident));
		v = {cfg_out.lmfc_adjust_resolution, 2'h0, cfg_out.lmfc_adjust_direction,
			cfg_out.phase_adjust_request};
		check("adjust", 34'h0, 34'(v));
		$display("test params done");
		// Lane count codes 0, 1 and 3 with whitening removal on and off
		foreach (SCRL_SET[i]) begin
			v = SCRL_SET[i];
			axw(12'h453, v, OK);
			axr(12'h453, v, OK);
			check("whiten", 34'(v[7]), 34'(cfg_out.payload_whitening_removal_enable));
			check("lanes", 34'(v[4:0]), 34'(cfg_out.lane_count_m1));
		end
		$display("test lanes done");
		// Capture in both checksum modes
		for (int m = 0; m < 2; m++) begin
			axw(12'h300, 8'(m << 6), OK);
			check("mode", 34'(m), 34'(cfg_out.checksum_mode));
			@(posedge clock);
			for (int k = 0; k < 3; k++) begin
				{ident[k], chk[k], so[k], sf[k]} <= 29'($random(seed));
			end
			send <= 3'b111;
			@(posedge clock);
			send <= 3'b000;
			repeat (3) @(posedge clock);
			for (int k = 0; k < 3; k++) begin
				axr(12'h435 + 12'(8 * k), chk[k], OK);
				axr(12'h436 + 12'(8 * k), m ? sf[k] : so[k], OK);
				if (k > 0) axr(12'h432 + 12'(8 * k), {3'h0, ident[k]}, OK);
			end
		end
		$display("test capture done");
		// Second reset in mid-run clears captured fields and restores defaults
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		check("whiten rst", 34'h1, 34'(cfg_out.payload_whitening_removal_enable));
		check("lanes rst", 34'h3, 34'(cfg_out.lane_count_m1));
		resetn <= 1'b1;
		axr(12'h435, 8'h00, OK);
		axr(12'h446, 8'h00, OK);
		axr(12'h43a, 8'h00, OK);
		axr(12'h453, 8'h83, OK);
		$display("test rereset done");
		repeat (4) @(posedge clock);
		complete_run();
	end
endmodule
